// ### src/asr_pkg.sv
// Shared constants for the serial converter readout link
package asr_pkg;
   // =========================================================
   // Result format
   localparam int RES_BITS       = 12;
   localparam int FRAME_CLOCKS   = 13;
   // =========================================================
   // Timing at the 250 MHz system clock
   localparam int SYS_CLK_MHZ    = 250;
   localparam int CONV_TIME_NS   = 8500;
   localparam int CONV_CYCLES    = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int SCLK_MAX_KHZ   = 2770;
   localparam int SCLK_HALF_CYC  =
      (SYS_CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   localparam int CS_IDLE_CYC    = 64;
   // =========================================================
   // Master transfer modes
   localparam logic MODE_BYTES   = 1'h0;
   localparam logic MODE_MIN13   = 1'h1;
endpackage : asr_pkg

// ### src/asr_link_if.sv
// Three-wire link between converter end and serial master end
`timescale 1ns/1ns
`default_nettype none
interface asr_link_if;
   logic cs_n;
   logic sclk;
   logic dout;
   modport dev (input cs_n, input sclk, output dout);
   modport mst (output cs_n, output sclk, input dout);
endinterface : asr_link_if
`default_nettype wire

// ### src/asr_device.sv
// Converter end: conversion start, end-of-conversion flag, result shifter
`timescale 1ns/1ns
`default_nettype none
module asr_device
   import asr_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
)(
   // System
   input  wire logic                I_CLK,
   input  wire logic                I_RST,
   // Sample to convert
   input  wire logic [RES_BITS-1:0] I_SAMPLE,
   // Link
   asr_link_if.dev                  link
);
   initial begin
      if (CONV_CYC < 1) $error("CONV_CYC must be at least 1");
      if (CONV_CYC > 65536) $error("CONV_CYC too large for counter");
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CONV = 2'h1,
      ST_SHFT = 2'h2
   } asr_dev_state_t;

   // =========================================================
   // Pin synchronisers
   logic [1:0]          cs_sync;
   logic [1:0]          sck_sync;
   logic                cs_q;
   logic                sck_q;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         cs_sync  <= 2'h3;
         sck_sync <= 2'h0;
         cs_q     <= 1'h1;
         sck_q    <= 1'h0;
      end else begin
         cs_sync  <= {cs_sync[0], link.cs_n};
         sck_sync <= {sck_sync[0], link.sclk};
         cs_q     <= cs_sync[1];
         sck_q    <= sck_sync[1];
      end
   end
   wire cs_fall  = cs_q & ~cs_sync[1];
   wire sck_fall = sck_q & ~sck_sync[1];

   // =========================================================
   // Conversion and shifting
   asr_dev_state_t      state;
   logic [15:0]         conv_cnt;
   logic [RES_BITS:0]   shreg;
   logic                dout;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         state    <= ST_IDLE;
         conv_cnt <= 16'h0000;
         shreg    <= '0;
         dout     <= 1'h0;
      end else if (cs_sync[1]) begin
         state <= ST_IDLE;
         dout  <= 1'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cs_fall) begin
                  state    <= ST_CONV;
                  conv_cnt <= 16'(CONV_CYC - 1);
                  shreg    <= {1'h1, I_SAMPLE};
                  dout     <= 1'h0;
               end
            end
            ST_CONV: begin
               if (conv_cnt == 16'h0000) begin
                  state <= ST_SHFT;
                  dout  <= 1'h1;
                  shreg <= {shreg[RES_BITS-1:0], 1'h0};
               end else begin
                  conv_cnt <= conv_cnt - 16'h0001;
               end
            end
            ST_SHFT: begin
               if (sck_fall) begin
                  dout  <= shreg[RES_BITS];
                  shreg <= {shreg[RES_BITS-1:0], 1'h0};
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // The leading one doubles as the end-of-conversion flag, so the first
   // fall after it shows the MSB; the remaining frame is 12 bits in MODE_MIN13 and 15 in MODE_BYTES.
   assign link.dout = dout;
endmodule : asr_device
`default_nettype wire

// ### src/asr_master.sv
// Serial master end: select, clock divider, sampling and result buffer
`timescale 1ns/1ns
`default_nettype none
module asr_master
   import asr_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC,
   parameter int WAIT_CYC = CONV_CYCLES
)(
   // System
   input  wire logic                I_CLK,
   input  wire logic                I_RST,
   // Request
   input  wire logic                I_START,
   input  wire logic                I_MODE,
   input  wire logic                I_USE_TIMEOUT,
   output logic                     O_BUSY,
   // Result stream
   output logic [RES_BITS-1:0]      O_DATA,
   output logic                     O_VALID,
   input  wire logic                I_READY,
   // Link
   asr_link_if.mst                  link
);
   initial begin
      if (HALF_CYC < 2) $error("HALF_CYC must be at least 2");
      if (WAIT_CYC < 1) $error("WAIT_CYC must be at least 1");
      // The timer is 16 bits wide, including the timeout margin
      if (WAIT_CYC > 65531) $error("WAIT_CYC too large for timer");
      if (HALF_CYC > 65536) $error("HALF_CYC too large for timer");
   end

   typedef enum logic [2:0] {
      MS_IDLE = 3'h0,
      MS_WAIT = 3'h1,
      MS_LOW  = 3'h2,
      MS_HIGH = 3'h3,
      MS_DONE = 3'h4
   } asr_mst_state_t;

   // =========================================================
   // Two-entry result buffer
   logic [RES_BITS-1:0] buf_q [2];
   logic [1:0]          cnt;
   logic                wp;
   logic                rp;
   logic                push;
   logic [15:0]         shin;
   wire  in_ready = (cnt != 2'h2);
   wire  pop      = O_VALID & I_READY;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         cnt      <= 2'h0;
         wp       <= 1'h0;
         rp       <= 1'h0;
         buf_q[0] <= '0;
         buf_q[1] <= '0;
      end else begin
         if (push) begin
            buf_q[wp] <= shin[RES_BITS-1:0];
            wp        <= ~wp;
         end
         if (pop) rp <= ~rp;
         cnt <= cnt + 2'(push) - 2'(pop);
      end
   end
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_VALID <= 1'h0;
         O_DATA  <= '0;
      end else begin
         O_VALID <= (cnt - 2'(pop) + 2'(push)) != 2'h0;
         O_DATA  <= (pop || cnt == 2'h0) ?
                    ((cnt - 2'(pop) == 2'h0) ? shin[RES_BITS-1:0]
                                             : buf_q[~rp])
                    : buf_q[rp];
      end
   end

   // =========================================================
   // Link sequencer
   logic [1:0]          dout_sync;
   asr_mst_state_t      state;
   logic [15:0]         tmr;
   logic [4:0]          clks;
   logic                cs_n;
   logic                sclk;
   logic                mode;
   wire  [4:0] n_clks = (mode == MODE_BYTES) ? 5'h10 : 5'(FRAME_CLOCKS);
   always_ff @(posedge I_CLK) begin
      if (I_RST) dout_sync <= 2'h0;
      else       dout_sync <= {dout_sync[0], link.dout};
   end
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         state <= MS_IDLE;
         tmr   <= 16'h0000;
         clks  <= 5'h00;
         shin  <= 16'h0000;
         cs_n  <= 1'h1;
         sclk  <= 1'h0;
         mode  <= MODE_BYTES;
         push  <= 1'h0;
      end else begin
         push <= 1'h0;
         case (state)
            MS_IDLE: begin
               if (I_START && tmr == 16'h0000) begin
                  cs_n  <= 1'h0;
                  mode  <= I_MODE;
                  tmr   <= 16'(WAIT_CYC + 4);
                  clks  <= 5'h00;
                  state <= MS_WAIT;
               end else if (tmr != 16'h0000) begin
                  tmr <= tmr - 16'h0001;
               end
            end
            MS_WAIT: begin
               // Synchroniser delay is covered by the timeout margin
               if ((!I_USE_TIMEOUT && dout_sync[1]) ||
                   tmr == 16'h0000) begin
                  tmr   <= 16'(HALF_CYC - 1);
                  state <= MS_LOW;
               end else begin
                  tmr <= tmr - 16'h0001;
               end
            end
            MS_LOW: begin
               if (tmr == 16'h0000) begin
                  sclk  <= 1'h1;
                  // Sample the settled level at the rising edge
                  shin  <= {shin[14:0], dout_sync[1]};
                  clks  <= clks + 5'h01;
                  tmr   <= 16'(HALF_CYC - 1);
                  state <= MS_HIGH;
               end else begin
                  tmr <= tmr - 16'h0001;
               end
            end
            MS_HIGH: begin
               if (tmr == 16'h0000) begin
                  sclk <= 1'h0;
                  tmr  <= 16'(HALF_CYC - 1);
                  if (clks == n_clks) state <= MS_DONE;
                  else                state <= MS_LOW;
               end else begin
                  tmr <= tmr - 16'h0001;
               end
            end
            MS_DONE: begin
               // Back-pressure: hold select low until the buffer has room
               if (in_ready && tmr == 16'h0000) begin
                  cs_n  <= 1'h1;
                  push  <= 1'h1;
                  if (mode == MODE_BYTES)
                     shin <= {3'h0, shin[15:3]};
                  tmr   <= 16'(CS_IDLE_CYC);
                  state <= MS_IDLE;
               end else if (tmr != 16'h0000) begin
                  tmr <= tmr - 16'h0001;
               end
            end
            default: state <= MS_IDLE;
         endcase
      end
   end
   always_ff @(posedge I_CLK) begin
      if (I_RST) O_BUSY <= 1'h0;
      else       O_BUSY <= (state != MS_IDLE) || I_START;
   end
   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
endmodule : asr_master
`default_nettype wire

// ### tb/asr_properties.sv
// Concurrent checks on the three-wire converter link
`timescale 1ns/1ns
`default_nettype none
module asr_properties
   import asr_pkg::*;
(
   // System
   input wire logic I_CLK,
   input wire logic I_RST,
   // Link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout
);
   // ==========================================================
   // Rising shift-clock edges counted inside a frame
   logic       sclk_q;
   logic [4:0] n_rise;
   always_ff @(posedge I_CLK) begin
      sclk_q <= I_RST ? 1'b0 : sclk;
   end
   always_ff @(posedge I_CLK) begin
      if (I_RST || cs_n) begin
         n_rise <= 5'h00;
      end else if (sclk && !sclk_q) begin
         n_rise <= n_rise + 5'h01;
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   sequence s_start; $fell(cs_n); endsequence
   sequence s_busy; (!dout)[*8]; endsequence
   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("shift clock high outside a frame");
   a_conv_busy_low: assert property (s_start |-> ##4 s_busy)
      else $error("output not low during conversion");
   a_conv_end_high: assert property (s_start |-> ##[10:40] $rose(dout))
      else $error("no end of conversion");
   a_out_moves_low: assert property ($changed(dout) |-> !sclk)
      else $error("output moved while shift clock high");
   a_select_idle: assert property (cs_n[*5] |-> !dout)
      else $error("output active while deselected");
   a_lead_one: assert property (sclk && !sclk_q && n_rise == 5'h00 |-> dout)
      else $error("first bit is not the leading one");
   a_trail_zero: assert property (sclk && !sclk_q && n_rise >= 5'h0D |-> !dout)
      else $error("trailing bit is not zero");
   a_clock_count: assert property ($rose(cs_n) |-> n_rise == 5'h0D || n_rise == 5'h10)
      else $error("frame clock count wrong");
endmodule // asr_properties
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the converter link, both ends joined
`timescale 1ns/1ns
`default_nettype none
module testbench
   import asr_pkg::*;
;
   typedef struct packed {logic [11:0] smp; logic mode; logic tmo;} asr_row_t;
   // ==========================================================
   // Ordinary frames: the word read back equals the sample
   localparam asr_row_t ROWS [4] = '{'{12'hFFF, MODE_BYTES, 1'h0},
      '{12'h000, MODE_MIN13, 1'h0}, '{12'hA5C, MODE_BYTES, 1'h1},
      '{12'h5A3, MODE_MIN13, 1'h1}};
   logic        clk, rst, start, mode, tmo, ready, busy, valid;
   logic [11:0] smp, data;
   int          err_count, n_tests, cyc;
   asr_link_if asr_link_if_inst ();
   asr_device #(.CONV_CYC(20)) asr_device_inst (.I_CLK(clk), .I_RST(rst),
      .I_SAMPLE(smp), .link(asr_link_if_inst));
   asr_master #(.HALF_CYC(8), .WAIT_CYC(40)) asr_master_inst (.I_CLK(clk),
      .I_RST(rst), .I_START(start), .I_MODE(mode), .I_USE_TIMEOUT(tmo),
      .O_BUSY(busy), .O_DATA(data), .O_VALID(valid), .I_READY(ready),
      .link(asr_link_if_inst));
   asr_properties asr_properties_inst (.I_CLK(clk), .I_RST(rst),
      .cs_n(asr_link_if_inst.cs_n), .sclk(asr_link_if_inst.sclk),
      .dout(asr_link_if_inst.dout));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Frames last about 240 to 310 cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_count++;
         give_verdict();
      end
   end
   task check(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict();
      $display("mismatches %0d, checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task frame(input asr_row_t r);
      @(posedge clk);
      smp <= r.smp;
      mode <= r.mode;
      tmo <= r.tmo;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask
   // Bounded by the cycle ceiling above
   task wait_idle();
      repeat (4) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      repeat (CS_IDLE_CYC) @(posedge clk);
   endtask
   // A word counts as taken only at an edge with valid and ready both high
   task get_word(input logic [11:0] exp);
      while ((valid & ready) !== 1'b1) @(posedge clk);
      check(data, exp);
      @(posedge clk);
   endtask
   initial begin
      {rst, start, mode, tmo, ready, smp} = {1'b1, 4'h1, 12'h000};
      {err_count, n_tests, cyc} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         frame(ROWS[i]);
         get_word(ROWS[i].smp);
         wait_idle();
      end
      // Receiver stalls: two words fill the buffer, the third frame holds
      @(posedge clk) ready <= 1'b0;
      frame('{12'h801, MODE_MIN13, 1'h0});
      wait_idle();
      frame('{12'h7FE, MODE_BYTES, 1'h0});
      wait_idle();
      frame('{12'h3C3, MODE_MIN13, 1'h1});
      repeat (600) @(posedge clk);
      check({11'h000, asr_link_if_inst.cs_n}, 12'h000);
      check({11'h000, busy}, 12'h001);
      @(posedge clk) ready <= 1'b1;
      get_word(12'h801);
      get_word(12'h7FE);
      get_word(12'h3C3);
      wait_idle();
      // Reset in mid-run returns both ends to idle
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({7'h00, valid, busy, asr_link_if_inst.cs_n,
         asr_link_if_inst.sclk, asr_link_if_inst.dout}, 12'h004);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
